// [design/adar_pkg.sv]
// adar_pkg: register map, field layout, reset values and cycle counts
// for the aperture delay adjust register block.
// assumes a byte-wide register port on the sample clock.
package adar_pkg;

   // ***************************************************************
   // register byte addresses
   // ***************************************************************
   localparam logic [11:0] ADDR_STATUS_B0 = 12'h2B2;
   localparam logic [11:0] ADDR_STATUS_B1 = 12'h2B3;
   localparam logic [11:0] ADDR_STATUS_B2 = 12'h2B4;
   localparam logic [11:0] ADDR_MANUAL_B0 = 12'h2B5;
   localparam logic [11:0] ADDR_MANUAL_B1 = 12'h2B6;
   localparam logic [11:0] ADDR_MANUAL_B2 = 12'h2B7;
   localparam logic [11:0] ADDR_RAMP_CTRL = 12'h2B8;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int RES_W = 17;
   localparam int INVERT_BIT = 16;
   localparam int DONE_BIT = 17;
   localparam int COARSE_LSB = 8;
   localparam int RAMP_EN_BIT = 0;
   localparam int RAMP_RATE_BIT = 1;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [16:0] MANUAL_RESET = 17'h00000;
   localparam logic [1:0] RAMP_CTRL_RESET = 2'h0;
   localparam logic [16:0] RESULT_RESET = 17'h00000;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // ***************************************************************
   // cycle counts and ramp step sizes
   // ***************************************************************
   localparam int RAMP_PERIOD_CYC = 256;
   localparam int FULL_APPLY_CYC = 1024;
   localparam logic [7:0] STEP_SLOW = 8'h01;
   localparam logic [7:0] STEP_FAST = 8'h04;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef struct packed {
      logic invert;
      logic [7:0] coarse;
      logic [7:0] fine;
   } adar_delay_t;

   typedef enum logic [1:0] {
      ADAR_IDLE = 2'b00,
      ADAR_RUN = 2'b01,
      ADAR_DONE = 2'b10
   } adar_cal_state_t;

endpackage

// [design/adar_coarse_ramp.sv]
// adar_coarse_ramp: steps the applied coarse delay toward its target.
// assumes target comes from flops on the same clock.
`timescale 1ns/10ps
module adar_coarse_ramp #(
   parameter int PERIOD_CYC = adar_pkg::RAMP_PERIOD_CYC
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // control
   input wire logic ramp_en,
   input wire logic fast_rate,
   input wire logic [7:0] target,
   // result
   output logic [7:0] coarse,
   output logic busy
);

   localparam int TW = $clog2(PERIOD_CYC);

   initial
   begin
      if (PERIOD_CYC < 2 || (1 << TW) != PERIOD_CYC)
         $error("adar_coarse_ramp: PERIOD_CYC must be a power of two");
   end

   logic [7:0] coarse_reg, coarse_next;
   logic [TW-1:0] tick_reg, tick_next;
   logic [7:0] step;
   logic [7:0] gap;

   always_comb
   begin
      coarse_next = coarse_reg;
      tick_next = tick_reg;
      step = fast_rate ? adar_pkg::STEP_FAST : adar_pkg::STEP_SLOW;
      gap = (target > coarse_reg) ? target - coarse_reg : coarse_reg - target;
      if (!ramp_en)
      begin
         // one cycle, well inside the full-apply bound
         coarse_next = target;
         tick_next = '0;
      end
      else
      begin
         tick_next = tick_reg + 1'b1;
         if (tick_reg == TW'(PERIOD_CYC - 1) && gap != 8'h00)
         begin
            // never overshoot the written value
            if (gap < step)
               step = gap;
            coarse_next = (target > coarse_reg) ? coarse_reg + step
                                                : coarse_reg - step;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         coarse_reg <= 8'h00;
         tick_reg <= '0;
      end
      else
      begin
         coarse_reg <= coarse_next;
         tick_reg <= tick_next;
      end
   end

   assign coarse = coarse_reg;
   assign busy = (coarse_reg != target);

endmodule // adar_coarse_ramp

// [design/adar_delay_regs.sv]
// adar_delay_regs: calibration status word, manual delay register and
// coarse ramp control, driving the applied sample-clock delay.
// assumes the calibration engine and the enable register sit outside,
// on the same clock, and follow the software-side constraints.
// Function
// - done flag needs enable and finished sequence
// - 17-bit result in status bits 16:0
// - result: invert, coarse byte, fine byte
// - manual setting applies only with calibration off
// - manual bit16 invert, 15:8 coarse, 7:0 fine
// - fine delay accepted any time, glitch free
// - manual register spans three bytes, resets zero
// - status read-only, bits 23:18 reserved
// - enable rising edge starts sequence, ignores manual
// - coarse applied within 1024, or counter ramps
// - ramp one or four codes per 256
`timescale 1ns/10ps
module adar_delay_regs #(
   parameter int ADDR_W = 12,
   parameter int RAMP_PERIOD = adar_pkg::RAMP_PERIOD_CYC
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // calibration engine
   input wire logic auto_cal_enable,
   input wire logic cal_seq_done,
   input wire logic [16:0] cal_seq_result,
   output logic cal_seq_start,
   // status
   output logic cal_complete_flag,
   output logic coarse_ramp_busy,
   // applied delay
   output adar_pkg::adar_delay_t applied_delay
);

   initial
   begin
      if (ADDR_W < 10)
         $error("adar_delay_regs: ADDR_W too small for register map");
      if (RAMP_PERIOD > adar_pkg::FULL_APPLY_CYC)
         $error("adar_delay_regs: RAMP_PERIOD out of range");
   end

   // ***************************************************************
   // decode helpers
   // ***************************************************************
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ref_a);
      hit = (a == ADDR_W'(ref_a));
   endfunction

   function automatic logic [7:0] pick_byte(input logic [23:0] w, input logic [1:0] idx);
      case (idx)
         2'h0: pick_byte = w[7:0];
         2'h1: pick_byte = w[15:8];
         2'h2: pick_byte = w[23:16];
         default: pick_byte = 8'h00;
      endcase
   endfunction

   // ***************************************************************
   // register file
   // ***************************************************************
   logic [16:0] manual_reg, manual_next;
   logic [1:0] ramp_ctrl_reg, ramp_ctrl_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic [23:0] status_word;
   logic [23:0] manual_word;

   always_comb
   begin
      manual_next = manual_reg;
      ramp_ctrl_next = ramp_ctrl_reg;
      if (reg_wr)
      begin
         // writes are stored even while calibration runs; only use is gated
         if (hit(reg_addr, adar_pkg::ADDR_MANUAL_B0))
            manual_next[7:0] = reg_wdata;
         if (hit(reg_addr, adar_pkg::ADDR_MANUAL_B1))
            manual_next[15:8] = reg_wdata;
         if (hit(reg_addr, adar_pkg::ADDR_MANUAL_B2))
            manual_next[16] = reg_wdata[0];
         if (hit(reg_addr, adar_pkg::ADDR_RAMP_CTRL))
            ramp_ctrl_next = reg_wdata[1:0];
      end
   end

   // ***************************************************************
   // calibration status
   // ***************************************************************
   adar_pkg::adar_cal_state_t cal_state_reg, cal_state_next;
   logic [16:0] result_reg, result_next;
   logic en_prev_reg, en_prev_next;
   logic start_reg, start_next;
   logic start_now;

   assign start_now = auto_cal_enable && !en_prev_reg;

   always_comb
   begin
      cal_state_next = cal_state_reg;
      result_next = result_reg;
      en_prev_next = auto_cal_enable;
      start_next = start_now;
      case (cal_state_reg)
         adar_pkg::ADAR_IDLE:
         begin
            if (start_now)
               cal_state_next = adar_pkg::ADAR_RUN;
         end
         adar_pkg::ADAR_RUN:
         begin
            if (!auto_cal_enable)
               cal_state_next = adar_pkg::ADAR_IDLE;
            else if (cal_seq_done)
            begin
               cal_state_next = adar_pkg::ADAR_DONE;
               result_next = cal_seq_result;
            end
         end
         adar_pkg::ADAR_DONE:
         begin
            // held until a fresh start so software reads one value
            if (start_now)
               cal_state_next = adar_pkg::ADAR_RUN;
         end
         default:
            cal_state_next = adar_pkg::ADAR_IDLE;
      endcase
      // a finish in the same cycle as a new start still lands, unless the block was idle
      if (start_now && cal_seq_done && cal_state_reg != adar_pkg::ADAR_IDLE)
      begin
         cal_state_next = adar_pkg::ADAR_DONE;
         result_next = cal_seq_result;
      end
   end

   // not in the cycle the enable rises: that cycle starts a new sequence
   assign cal_complete_flag = auto_cal_enable && en_prev_reg &&
      (cal_state_reg == adar_pkg::ADAR_DONE);

   // ***************************************************************
   // read path
   // ***************************************************************
   assign status_word = {6'h00, cal_complete_flag, result_reg};
   assign manual_word = {7'h00, manual_reg};

   always_comb
   begin
      rvalid_next = reg_rd;
      rdata_next = rdata_reg;
      if (reg_rd)
      begin
         if (hit(reg_addr, adar_pkg::ADDR_STATUS_B0))
            rdata_next = pick_byte(status_word, 2'h0);
         else if (hit(reg_addr, adar_pkg::ADDR_STATUS_B1))
            rdata_next = pick_byte(status_word, 2'h1);
         else if (hit(reg_addr, adar_pkg::ADDR_STATUS_B2))
            rdata_next = pick_byte(status_word, 2'h2);
         else if (hit(reg_addr, adar_pkg::ADDR_MANUAL_B0))
            rdata_next = pick_byte(manual_word, 2'h0);
         else if (hit(reg_addr, adar_pkg::ADDR_MANUAL_B1))
            rdata_next = pick_byte(manual_word, 2'h1);
         else if (hit(reg_addr, adar_pkg::ADDR_MANUAL_B2))
            rdata_next = pick_byte(manual_word, 2'h2);
         else if (hit(reg_addr, adar_pkg::ADDR_RAMP_CTRL))
            rdata_next = {6'h00, ramp_ctrl_reg};
         else
            rdata_next = adar_pkg::RDATA_RESET;
      end
   end

   // ***************************************************************
   // applied delay selection
   // ***************************************************************
   logic invert_reg, invert_next;
   logic [7:0] fine_reg, fine_next;
   logic [7:0] coarse_target;
   logic [7:0] coarse_now;

   always_comb
   begin
      invert_next = invert_reg;
      fine_next = fine_reg;
      coarse_target = coarse_now;
      if (!auto_cal_enable)
      begin
         invert_next = manual_reg[adar_pkg::INVERT_BIT];
         fine_next = manual_reg[7:0];
         coarse_target = manual_reg[15:adar_pkg::COARSE_LSB];
      end
      else if (cal_state_reg == adar_pkg::ADAR_DONE)
      begin
         // manual register ignored while calibration is on
         invert_next = result_reg[adar_pkg::INVERT_BIT];
         fine_next = result_reg[7:0];
         coarse_target = result_reg[15:adar_pkg::COARSE_LSB];
      end
   end

   adar_coarse_ramp #(
      .PERIOD_CYC(RAMP_PERIOD)
   ) u_ramp (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ramp_en(ramp_ctrl_reg[adar_pkg::RAMP_EN_BIT]),
      .fast_rate(ramp_ctrl_reg[adar_pkg::RAMP_RATE_BIT]),
      .target(coarse_target),
      .coarse(coarse_now),
      .busy(coarse_ramp_busy)
   );

   // ***************************************************************
   // state registers
   // ***************************************************************
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         manual_reg <= adar_pkg::MANUAL_RESET;
         ramp_ctrl_reg <= adar_pkg::RAMP_CTRL_RESET;
         rdata_reg <= adar_pkg::RDATA_RESET;
         rvalid_reg <= 1'b0;
         cal_state_reg <= adar_pkg::ADAR_IDLE;
         result_reg <= adar_pkg::RESULT_RESET;
         en_prev_reg <= 1'b0;
         start_reg <= 1'b0;
         invert_reg <= 1'b0;
         fine_reg <= 8'h00;
      end
      else
      begin
         manual_reg <= manual_next;
         ramp_ctrl_reg <= ramp_ctrl_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         cal_state_reg <= cal_state_next;
         result_reg <= result_next;
         en_prev_reg <= en_prev_next;
         start_reg <= start_next;
         invert_reg <= invert_next;
         fine_reg <= fine_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;
   assign cal_seq_start = start_reg;
   assign applied_delay.invert = invert_reg;
   assign applied_delay.coarse = coarse_now;
   assign applied_delay.fine = fine_reg;

endmodule // adar_delay_regs

// [tb/adar_delay_regs_assertions.sv]
// adar_delay_regs_assertions: port-level timing checks of the delay block.
// assumes a bind onto adar_delay_regs, one clock, sync active-low reset.
`timescale 1ns/10ps
module adar_delay_regs_assertions #(
   parameter int ADDR_W = 12,
   parameter int RAMP_PERIOD = 256
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   // calibration and delay
   input wire logic auto_cal_enable,
   input wire logic cal_seq_done,
   input wire logic [16:0] cal_seq_result,
   input wire logic cal_seq_start,
   input wire logic cal_complete_flag,
   input wire logic coarse_ramp_busy,
   input wire adar_pkg::adar_delay_t applied_delay
);
   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_RVALID: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered next cycle");
   AST_START: assert property ($rose(auto_cal_enable) |=> cal_seq_start)
      else $error("enable rise gave no start");
   AST_START_SRC: assert property (cal_seq_start |-> $past(auto_cal_enable) &&
      !$past(auto_cal_enable, 2)) else $error("start without enable rise");
   AST_FLAG_EN: assert property (cal_complete_flag |-> auto_cal_enable)
      else $error("done flag without enable");
   AST_EN_RISE_FLAG: assert property ($rose(auto_cal_enable) |-> !cal_complete_flag)
      else $error("done flag high as a new sequence starts");
   AST_FLAG_RISE: assert property ($rose(cal_complete_flag) |-> $past(cal_seq_done))
      else $error("done flag rose without finished sequence");
   AST_HOLD: assert property (cal_complete_flag && $past(cal_complete_flag, 2)
      |-> $stable(applied_delay.fine) && $stable(applied_delay.invert))
      else $error("calibration result moved while done");
   AST_FINE: assert property (reg_wr && reg_addr == adar_pkg::ADDR_MANUAL_B0 &&
      !auto_cal_enable ##1 !auto_cal_enable |=> applied_delay.fine == $past(reg_wdata, 2))
      else $error("manual fine not applied");
   AST_INVERT: assert property (reg_wr && reg_addr == adar_pkg::ADDR_MANUAL_B2 &&
      !auto_cal_enable ##1 !auto_cal_enable |=> applied_delay.invert == $past(reg_wdata[0], 2))
      else $error("manual invert not applied");
   AST_STATUS_RSVD: assert property (reg_rd && reg_addr == adar_pkg::ADDR_STATUS_B2
      |=> reg_rdata[7:2] == 6'h00) else $error("status reserved bits set");
   AST_MANUAL_RSVD: assert property (reg_rd && reg_addr == adar_pkg::ADDR_MANUAL_B2
      |=> reg_rdata[7:1] == 7'h00) else $error("manual reserved bits set");
endmodule // adar_delay_regs_assertions

// [tb/testbench.sv]
// testbench: register, ramp and calibration scenarios for adar_delay_regs.
// assumes the bench stands in for software and the calibration engine.
`timescale 1ns/10ps
module testbench;
   // short ramp period keeps the run brief
   localparam int PER = 4;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic auto_cal_enable = 1'b0;
   logic cal_seq_done = 1'b0;
   logic [16:0] cal_seq_result = 17'h00000;
   logic cal_seq_start;
   logic cal_complete_flag;
   logic coarse_ramp_busy;
   adar_pkg::adar_delay_t applied_delay;
   logic [7:0] exp_q[$];
   logic [16:0] man;
   logic [16:0] res;
   logic [7:0] tgt;
   logic [7:0] prev;
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;
   int seed = 91;
   int n;

   adar_delay_regs #(.ADDR_W(12), .RAMP_PERIOD(PER)) adar_delay_regs_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .auto_cal_enable(auto_cal_enable), .cal_seq_done(cal_seq_done),
      .cal_seq_result(cal_seq_result), .cal_seq_start(cal_seq_start),
      .cal_complete_flag(cal_complete_flag), .coarse_ramp_busy(coarse_ramp_busy),
      .applied_delay(applied_delay));

   initial
   begin
      forever #4 ref_clk = ~ref_clk;
   end

   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      if (err_total == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   task automatic done_pulse(input logic [16:0] r);
      @(posedge ref_clk);
      cal_seq_done <= 1'b1;
      cal_seq_result <= r;
      @(posedge ref_clk);
      cal_seq_done <= 1'b0;
      cal_seq_result <= ~r;
   endtask

   // ***************************************************************
   // read monitor and timeout
   // ***************************************************************
   always @(negedge ref_clk)
   begin
      if (reg_rvalid === 1'b1)
      begin
         if (exp_q.size() > 0)
            check({9'h000, reg_rdata}, {9'h000, exp_q.pop_front()});
         else
            check(17'h00001, 17'h00000);
      end
   end

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles > 5000)
      begin
         err_total++;
         test_done();
      end
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(adar_pkg::ADDR_MANUAL_B0, 8'h00);
      rd(adar_pkg::ADDR_MANUAL_B1, 8'h00);
      rd(adar_pkg::ADDR_MANUAL_B2, 8'h00);
      rd(adar_pkg::ADDR_RAMP_CTRL, 8'h00);
      rd(12'h2B9, 8'h00);
      check(applied_delay, 17'h00000);
      man = {1'b1, 1'b0, 7'($random(seed)), 8'($random(seed))};
      wr(adar_pkg::ADDR_MANUAL_B0, man[7:0]);
      wr(adar_pkg::ADDR_MANUAL_B1, man[15:8]);
      // converter calibration and link are off, so inversion may change
      wr(adar_pkg::ADDR_MANUAL_B2, 8'hFF);
      rd(adar_pkg::ADDR_MANUAL_B0, man[7:0]);
      rd(adar_pkg::ADDR_MANUAL_B1, man[15:8]);
      rd(adar_pkg::ADDR_MANUAL_B2, 8'h01);
      check(applied_delay, man);
      // slow then fast ramp, each three ticks long
      for (int m = 0; m < 2; m++)
      begin
         tgt = man[15:8] + (m == 1 ? 8'h0A : 8'h03);
         prev = man[15:8];
         wr(adar_pkg::ADDR_RAMP_CTRL, {6'h3F, m[0], 1'b1});
         rd(adar_pkg::ADDR_RAMP_CTRL, {6'h00, m[0], 1'b1});
         wr(adar_pkg::ADDR_MANUAL_B1, tgt);
         n = 0;
         @(negedge ref_clk);
         while (coarse_ramp_busy === 1'b1 && n < 100)
         begin
            @(negedge ref_clk);
            n++;
            check(17'(applied_delay.coarse - prev > (m == 1 ? 4 : 1)), 17'h0);
            prev = applied_delay.coarse;
         end
         check(applied_delay.coarse, tgt);
         check(17'(n >= 2 * PER && n <= 3 * PER + 2), 17'h1);
         man[15:8] = tgt;
      end
      // ramp off: a large jump lands at once
      wr(adar_pkg::ADDR_RAMP_CTRL, 8'h00);
      man[15:8] = man[15:8] ^ 8'h80;
      // large jump allowed: converter calibration and link are off
      wr(adar_pkg::ADDR_MANUAL_B1, man[15:8]);
      repeat (2) @(negedge ref_clk);
      check(applied_delay.coarse, man[15:8]);
      // a finish seen while idle must not count
      res = 17'($random(seed));
      done_pulse(~res);
      @(posedge ref_clk);
      auto_cal_enable <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(adar_pkg::ADDR_STATUS_B2, 8'h00);
      done_pulse(res);
      repeat (2) @(negedge ref_clk);
      check(cal_complete_flag, 17'h1);
      check({applied_delay.invert, applied_delay.fine}, {res[16], res[7:0]});
      wr(adar_pkg::ADDR_STATUS_B0, ~res[7:0]);
      wr(adar_pkg::ADDR_MANUAL_B0, ~res[7:0]);
      // copy the result's coarse and invert into the manual register
      wr(adar_pkg::ADDR_MANUAL_B1, res[15:8]);
      wr(adar_pkg::ADDR_MANUAL_B2, {7'h00, res[16]});
      rd(adar_pkg::ADDR_STATUS_B0, res[7:0]);
      rd(adar_pkg::ADDR_STATUS_B1, res[15:8]);
      rd(adar_pkg::ADDR_STATUS_B2, {6'h00, 1'b1, res[16]});
      check(applied_delay.fine, res[7:0]);
      @(posedge ref_clk);
      auto_cal_enable <= 1'b0;
      man = {res[16], res[15:8], ~res[7:0]};
      repeat (3) @(negedge ref_clk);
      check(cal_complete_flag, 17'h0);
      check(applied_delay, man);
      @(posedge ref_clk);
      auto_cal_enable <= 1'b1;
      repeat (3) @(negedge ref_clk);
      check(cal_complete_flag, 17'h0);
      repeat (3) @(negedge ref_clk);
      check(17'(exp_q.size()), 17'h0);
      test_done();
   end
endmodule // testbench

bind adar_delay_regs adar_delay_regs_assertions #(.ADDR_W(ADDR_W), .RAMP_PERIOD(RAMP_PERIOD))
   adar_delay_regs_assertions_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .auto_cal_enable(auto_cal_enable), .cal_seq_done(cal_seq_done),
   .cal_seq_result(cal_seq_result), .cal_seq_start(cal_seq_start),
   .cal_complete_flag(cal_complete_flag), .coarse_ramp_busy(coarse_ramp_busy),
   .applied_delay(applied_delay));
